// ### logic/ircr_pkg.sv
package ircr_pkg;

  // Register numbers as seen on the management register port.
  localparam logic [15:0] ADDR_RATE_CMD = 16'h184B;
  localparam logic [15:0] ADDR_RATE_CMD_STS = 16'h184C;
  localparam logic [15:0] ADDR_WR_STAGE = 16'h184D;
  localparam logic [15:0] ADDR_RD_STAGE = 16'h184E;
  localparam logic [15:0] ADDR_FILT_CNT0 = 16'h1850;
  localparam logic [15:0] ADDR_FILT_CNT1 = 16'h1851;
  localparam logic [15:0] ADDR_FILT_CNT2 = 16'h1852;
  localparam logic [15:0] ADDR_REGEN_TBL0 = 16'h1855;
  localparam logic [15:0] ADDR_REGEN_TBL1 = 16'h1856;

  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned REGEN_PORTS = 2;

  // Rate table command layout.
  localparam int unsigned CMD_START_BIT = 31;
  localparam int unsigned CMD_READ_BIT = 30;
  localparam int unsigned CMD_INDEX_LSB = 0;
  localparam int unsigned RATE_AW = 5;
  localparam int unsigned PEND_BIT = 0;

  // Rate table shape and reset contents.
  localparam int unsigned STAGE_W = 16;
  localparam int unsigned RATE_ENTRIES = 26;
  localparam logic [RATE_AW-1:0] COMMIT_ENTRIES = 5'h18;
  localparam logic [RATE_AW-1:0] CBS_INDEX = 5'h18;
  localparam logic [RATE_AW-1:0] EBS_INDEX = 5'h19;
  localparam logic [STAGE_W-1:0] COMMIT_RESET = 16'h0014;
  localparam logic [STAGE_W-1:0] BURST_RESET = 16'h0600;
  localparam logic [STAGE_W-1:0] STAGE_RESET = 16'h0000;

  // Priority regeneration table layout.
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned REGEN_ENTRIES = 8;
  localparam int unsigned REGEN_W = 24;
  localparam logic [REGEN_W-1:0] REGEN_RESET = 24'hFAC688;

  // Filtered packet counters.
  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFF_FFFF;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    IRCR_ST_IDLE = 2'b00,
    IRCR_ST_ACCESS = 2'b01,
    IRCR_ST_CAPTURE = 2'b10
  } ircr_cmd_state_t;

  function automatic logic [STAGE_W-1:0] rate_reset(input logic [RATE_AW-1:0] idx);
    rate_reset = (idx < COMMIT_ENTRIES) ? COMMIT_RESET : BURST_RESET;
  endfunction

endpackage

// ### logic/ircr_rate_mem.sv
`timescale 1ns/1ns
// Metering table storage. Every entry has its own reset value, so the
// array is built from resettable flops instead of a RAM macro.
module ircr_rate_mem (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [ircr_pkg::RATE_AW-1:0] wr_addr,
  input wire logic [ircr_pkg::STAGE_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [ircr_pkg::RATE_AW-1:0] rd_addr,
  output logic [ircr_pkg::STAGE_W-1:0] rd_data_q
);

  logic [ircr_pkg::STAGE_W-1:0] mem_q [ircr_pkg::RATE_ENTRIES];
  logic [ircr_pkg::STAGE_W-1:0] rd_data_d;

  genvar i;
  generate
    for (i = 0; i < ircr_pkg::RATE_ENTRIES; i++) begin : g_entry
      localparam logic [ircr_pkg::RATE_AW-1:0] IDX = ircr_pkg::RATE_AW'(i);
      logic [ircr_pkg::STAGE_W-1:0] ent_d;
      always_comb begin
        ent_d = mem_q[i];
        if (wr_en && (wr_addr == IDX)) begin
          ent_d = wr_data;
        end
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          mem_q[i] <= ircr_pkg::rate_reset(IDX);
        end else begin
          mem_q[i] <= ent_d;
        end
      end
    end
  endgenerate

  // Out-of-range indices read as zero rather than aliasing a real entry.
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en) begin
      if (rd_addr < ircr_pkg::RATE_ENTRIES[ircr_pkg::RATE_AW-1:0]) begin
        rd_data_d = mem_q[rd_addr];
      end else begin
        rd_data_d = ircr_pkg::STAGE_RESET;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= ircr_pkg::STAGE_RESET;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

endmodule

// ### logic/ircr_regs.sv
`timescale 1ns/1ns
// Function
// - Write staging value goes into the selected rate table entry on a write command.
// - Write staging bits 15:0 read-write, reset zero; bits 31:16 reserved read zero.
// - Read staging bits 15:0 show data fetched by a read command; reset zero.
// - One 32-bit filtered packet counter per switch port, one count per packet.
// - Broadcast throttling discards also count as filtered packets.
// - Ingress rate limiting drops are not counted here.
// - Counter read returns its value and clears it; reset value zero.
// - Counters saturate at all ones instead of wrapping.
// - Eight-entry table for each of ports 0 and 1 maps received VLAN priority to regenerated priority.
// - Output queue selection uses the regenerated priority for tagged packets.
// - Table packs 3-bit entries by priority, 7 at 23:21, 0 at 2:0.
// - After reset each table entry equals its own priority index.
// - Rate table holds 24 committed rate, one committed and one excess burst entry.
// - Pending flag at status bit 0 while a table command runs, self-clears.
module ircr_regs (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic [ircr_pkg::NUM_PORTS-1:0] filter_drop_evt,
  input wire logic [ircr_pkg::NUM_PORTS-1:0] bcast_throttle_evt,
  input wire logic [ircr_pkg::REGEN_PORTS-1:0] rx_valid,
  input wire logic [ircr_pkg::REGEN_PORTS-1:0] rx_tagged,
  input wire logic [ircr_pkg::PRIO_W-1:0] rx_vlan_prio [ircr_pkg::REGEN_PORTS],
  input wire logic [ircr_pkg::PRIO_W-1:0] rx_other_prio [ircr_pkg::REGEN_PORTS],
  output logic [ircr_pkg::REGEN_PORTS-1:0] queue_prio_valid_q,
  output logic [ircr_pkg::PRIO_W-1:0] queue_prio_q [ircr_pkg::REGEN_PORTS]
);

  // Register port decode.
  logic wr_cmd;
  logic wr_stage_sel;
  logic [ircr_pkg::NUM_PORTS-1:0] cnt_rd_sel;
  logic [ircr_pkg::REGEN_PORTS-1:0] regen_wr_sel;

  // Rate table command engine.
  ircr_pkg::ircr_cmd_state_t cmd_state_q;
  ircr_pkg::ircr_cmd_state_t cmd_state_d;
  logic pending_q;
  logic pending_d;
  logic cmd_read_q;
  logic cmd_read_d;
  logic [ircr_pkg::RATE_AW-1:0] cmd_index_q;
  logic [ircr_pkg::RATE_AW-1:0] cmd_index_d;
  logic [ircr_pkg::STAGE_W-1:0] wr_stage_q;
  logic [ircr_pkg::STAGE_W-1:0] wr_stage_d;
  logic [ircr_pkg::STAGE_W-1:0] rd_stage_q;
  logic [ircr_pkg::STAGE_W-1:0] rd_stage_d;
  logic mem_wr_en;
  logic mem_rd_en;
  logic [ircr_pkg::STAGE_W-1:0] mem_rd_data;

  // Counters and regeneration tables.
  logic [ircr_pkg::CNT_W-1:0] cnt_q [ircr_pkg::NUM_PORTS];
  logic [ircr_pkg::REGEN_W-1:0] regen_q [ircr_pkg::REGEN_PORTS];

  // Read answer.
  logic [31:0] reg_rdata_d;
  logic reg_rvalid_d;

  // Reads and writes never share a cycle, so the two strobes are decoded apart.
  assign wr_cmd = reg_wr && (reg_addr == ircr_pkg::ADDR_RATE_CMD);
  assign wr_stage_sel = reg_wr && (reg_addr == ircr_pkg::ADDR_WR_STAGE);

  // Per-port registers sit at consecutive numbers, so each port decodes
  // its own offset from the first one.
  genvar s;
  generate
    for (s = 0; s < ircr_pkg::NUM_PORTS; s++) begin : g_cnt_sel
      assign cnt_rd_sel[s] = reg_rd && (reg_addr == (ircr_pkg::ADDR_FILT_CNT0 + 16'(s)));
    end
    for (s = 0; s < ircr_pkg::REGEN_PORTS; s++) begin : g_regen_sel
      assign regen_wr_sel[s] = reg_wr && (reg_addr == (ircr_pkg::ADDR_REGEN_TBL0 + 16'(s)));
    end
  endgenerate

  // A command is taken only when none is running; a start written while
  // pending is dropped, since the staging registers are still in use.
  always_comb begin
    cmd_state_d = cmd_state_q;
    pending_d = pending_q;
    cmd_read_d = cmd_read_q;
    cmd_index_d = cmd_index_q;
    rd_stage_d = rd_stage_q;
    mem_wr_en = 1'b0;
    mem_rd_en = 1'b0;
    case (cmd_state_q)
      ircr_pkg::IRCR_ST_IDLE: begin
        if (wr_cmd && reg_wdata[ircr_pkg::CMD_START_BIT]) begin
          cmd_read_d = reg_wdata[ircr_pkg::CMD_READ_BIT];
          cmd_index_d = reg_wdata[ircr_pkg::CMD_INDEX_LSB +: ircr_pkg::RATE_AW];
          pending_d = 1'b1;
          cmd_state_d = ircr_pkg::IRCR_ST_ACCESS;
        end
      end
      ircr_pkg::IRCR_ST_ACCESS: begin
        if (cmd_read_q) begin
          mem_rd_en = 1'b1;
          cmd_state_d = ircr_pkg::IRCR_ST_CAPTURE;
        end else begin
          // Out-of-range indices are dropped so they cannot alias a real entry.
          if (cmd_index_q < ircr_pkg::RATE_ENTRIES[ircr_pkg::RATE_AW-1:0]) begin
            mem_wr_en = 1'b1;
          end
          pending_d = 1'b0;
          cmd_state_d = ircr_pkg::IRCR_ST_IDLE;
        end
      end
      ircr_pkg::IRCR_ST_CAPTURE: begin
        rd_stage_d = mem_rd_data;
        pending_d = 1'b0;
        cmd_state_d = ircr_pkg::IRCR_ST_IDLE;
      end
      default: begin
        pending_d = 1'b0;
        cmd_state_d = ircr_pkg::IRCR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_state_q <= ircr_pkg::IRCR_ST_IDLE;
      pending_q <= 1'b0;
      cmd_read_q <= 1'b0;
      cmd_index_q <= '0;
      rd_stage_q <= ircr_pkg::STAGE_RESET;
    end else begin
      cmd_state_q <= cmd_state_d;
      pending_q <= pending_d;
      cmd_read_q <= cmd_read_d;
      cmd_index_q <= cmd_index_d;
      rd_stage_q <= rd_stage_d;
    end
  end

  // The write staging word is a plain register; a write command copies
  // whatever it holds at the access cycle.
  always_comb begin
    wr_stage_d = wr_stage_q;
    if (wr_stage_sel) begin
      wr_stage_d = reg_wdata[ircr_pkg::STAGE_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_stage_q <= ircr_pkg::STAGE_RESET;
    end else begin
      wr_stage_q <= wr_stage_d;
    end
  end

  // Twenty-four committed rate entries indexed port*8+priority, then the
  // committed and excess burst sizes.
  ircr_rate_mem u_rate_mem (
    .core_clk(core_clk),
    .nrst(nrst),
    .wr_en(mem_wr_en),
    .wr_addr(cmd_index_q),
    .wr_data(wr_stage_q),
    .rd_en(mem_rd_en),
    .rd_addr(cmd_index_q),
    .rd_data_q(mem_rd_data)
  );

  // Per-port filtered packet counters. The event inputs are one-cycle
  // pulses per packet from the forwarding logic on this clock; rate limiter
  // drops have their own counters and never reach these inputs.
  genvar p;
  generate
    for (p = 0; p < ircr_pkg::NUM_PORTS; p++) begin : g_cnt
      logic hit;
      logic [ircr_pkg::CNT_W-1:0] cnt_d;
      assign hit = filter_drop_evt[p] || bcast_throttle_evt[p];
      // A packet that lands in the same cycle as the clearing read is kept
      // as the first count of the new interval, so no event is lost.
      always_comb begin
        cnt_d = cnt_q[p];
        if (cnt_rd_sel[p]) begin
          cnt_d = hit ? ircr_pkg::CNT_ONE : ircr_pkg::CNT_RESET;
        end else if (hit && (cnt_q[p] != ircr_pkg::CNT_MAX)) begin
          cnt_d = cnt_q[p] + ircr_pkg::CNT_ONE;
        end
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          cnt_q[p] <= ircr_pkg::CNT_RESET;
        end else begin
          cnt_q[p] <= cnt_d;
        end
      end
    end
  endgenerate

  // Priority regeneration tables and the queue priority they feed.
  generate
    for (p = 0; p < ircr_pkg::REGEN_PORTS; p++) begin : g_regen
      logic [ircr_pkg::REGEN_W-1:0] regen_d;
      logic [ircr_pkg::PRIO_W-1:0] mapped;
      logic [ircr_pkg::PRIO_W-1:0] prio_d;
      logic prio_valid_d;
      always_comb begin
        regen_d = regen_q[p];
        if (regen_wr_sel[p]) begin
          regen_d = reg_wdata[ircr_pkg::REGEN_W-1:0];
        end
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          regen_q[p] <= ircr_pkg::REGEN_RESET;
        end else begin
          regen_q[p] <= regen_d;
        end
      end
      // Entry n sits at bits 3n+2:3n.
      assign mapped = regen_q[p][rx_vlan_prio[p]*ircr_pkg::PRIO_W +: ircr_pkg::PRIO_W];
      // Untagged frames carry no VLAN priority, so they keep whatever
      // priority the other classifiers chose.
      always_comb begin
        prio_valid_d = rx_valid[p];
        prio_d = queue_prio_q[p];
        if (rx_valid[p]) begin
          prio_d = rx_tagged[p] ? mapped : rx_other_prio[p];
        end
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          queue_prio_q[p] <= '0;
          queue_prio_valid_q[p] <= 1'b0;
        end else begin
          queue_prio_q[p] <= prio_d;
          queue_prio_valid_q[p] <= prio_valid_d;
        end
      end
    end
  endgenerate

  // Read mux. Reserved bits of every register read as zero.
  // The command register reads back the command last taken, with the start
  // bit standing in for the pending flag, so software may poll either one.
  always_comb begin
    reg_rdata_d = reg_rdata_q;
    reg_rvalid_d = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        ircr_pkg::ADDR_RATE_CMD: begin
          reg_rdata_d = ircr_pkg::WORD_ZERO;
          reg_rdata_d[ircr_pkg::CMD_START_BIT] = pending_q;
          reg_rdata_d[ircr_pkg::CMD_READ_BIT] = cmd_read_q;
          reg_rdata_d[ircr_pkg::CMD_INDEX_LSB +: ircr_pkg::RATE_AW] = cmd_index_q;
        end
        ircr_pkg::ADDR_RATE_CMD_STS: begin
          reg_rdata_d = ircr_pkg::WORD_ZERO;
          reg_rdata_d[ircr_pkg::PEND_BIT] = pending_q;
        end
        ircr_pkg::ADDR_WR_STAGE: begin
          reg_rdata_d = {16'h0000, wr_stage_q};
        end
        ircr_pkg::ADDR_RD_STAGE: begin
          reg_rdata_d = {16'h0000, rd_stage_q};
        end
        ircr_pkg::ADDR_FILT_CNT0: begin
          reg_rdata_d = cnt_q[0];
        end
        ircr_pkg::ADDR_FILT_CNT1: begin
          reg_rdata_d = cnt_q[1];
        end
        ircr_pkg::ADDR_FILT_CNT2: begin
          reg_rdata_d = cnt_q[2];
        end
        ircr_pkg::ADDR_REGEN_TBL0: begin
          reg_rdata_d = {8'h00, regen_q[0]};
        end
        ircr_pkg::ADDR_REGEN_TBL1: begin
          reg_rdata_d = {8'h00, regen_q[1]};
        end
        default: begin
          reg_rdata_d = ircr_pkg::WORD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= ircr_pkg::WORD_ZERO;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rdata_q <= reg_rdata_d;
      reg_rvalid_q <= reg_rvalid_d;
    end
  end

endmodule

// ### testbench/ircr_regs_properties.sv
`timescale 1ns/1ns
module ircr_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  input wire logic [ircr_pkg::NUM_PORTS-1:0] filter_drop_evt,
  input wire logic [ircr_pkg::NUM_PORTS-1:0] bcast_throttle_evt,
  input wire logic [ircr_pkg::REGEN_PORTS-1:0] rx_valid,
  input wire logic [ircr_pkg::REGEN_PORTS-1:0] rx_tagged,
  input wire logic [ircr_pkg::PRIO_W-1:0] rx_other_prio [ircr_pkg::REGEN_PORTS],
  input wire logic [ircr_pkg::REGEN_PORTS-1:0] queue_prio_valid_q,
  input wire logic [ircr_pkg::PRIO_W-1:0] queue_prio_q [ircr_pkg::REGEN_PORTS]
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_cmd(r);
    reg_wr && reg_addr == ircr_pkg::ADDR_RATE_CMD && reg_wdata[31] && reg_wdata[30] == r;
  endsequence
  // A read with no event on port 0 in its own cycle must clear the count fully.
  sequence s_cnt0_rd;
    reg_rd && reg_addr == ircr_pkg::ADDR_FILT_CNT0 && !filter_drop_evt[0] && !bcast_throttle_evt[0];
  endsequence
  property p_rvalid;
    reg_rd |=> reg_rvalid_q;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_wr_upper;
    s_rd(ircr_pkg::ADDR_WR_STAGE) |=> reg_rdata_q[31:16] == 16'h0000;
  endproperty
  a_wr_upper: assert property (p_wr_upper) else $error("write staging upper bits set");
  property p_rd_upper;
    s_rd(ircr_pkg::ADDR_RD_STAGE) |=> reg_rdata_q[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read staging upper bits set");
  property p_regen_upper;
    reg_rd && (reg_addr == ircr_pkg::ADDR_REGEN_TBL0 || reg_addr == ircr_pkg::ADDR_REGEN_TBL1)
      |=> reg_rdata_q[31:24] == 8'h00;
  endproperty
  a_regen_upper: assert property (p_regen_upper) else $error("table upper bits set");
  property p_sts_upper;
    s_rd(ircr_pkg::ADDR_RATE_CMD_STS) |=> reg_rdata_q[31:1] == 31'h0;
  endproperty
  a_sts_upper: assert property (p_sts_upper) else $error("status upper bits set");
  property p_cnt_clear;
    s_cnt0_rd ##1 (!filter_drop_evt[0] && !bcast_throttle_evt[0]) ##1 s_cnt0_rd
      |=> reg_rdata_q == 32'h0000_0000;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared by read");
  property p_pend_wr;
    s_cmd(1'b0) ##1 s_rd(ircr_pkg::ADDR_RATE_CMD_STS) |=> reg_rdata_q[0];
  endproperty
  a_pend_wr: assert property (p_pend_wr) else $error("pending not set by command");
  property p_pend_done;
    s_cmd(1'b1) ##3 s_rd(ircr_pkg::ADDR_RATE_CMD_STS) |=> !reg_rdata_q[0];
  endproperty
  a_pend_done: assert property (p_pend_done) else $error("pending not cleared");
  property p_qvalid;
    rx_valid[0] |=> queue_prio_valid_q[0];
  endproperty
  a_qvalid: assert property (p_qvalid) else $error("queue priority not presented");
  property p_untagged;
    rx_valid[1] && !rx_tagged[1] |=> queue_prio_q[1] == $past(rx_other_prio[1]);
  endproperty
  a_untagged: assert property (p_untagged) else $error("untagged priority altered");
  property p_qhold;
    !rx_valid[0] |=> $stable(queue_prio_q[0]);
  endproperty
  a_qhold: assert property (p_qhold) else $error("queue priority moved without packet");
endmodule
bind ircr_regs ircr_props u_props (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .filter_drop_evt(filter_drop_evt),
  .bcast_throttle_evt(bcast_throttle_evt), .rx_valid(rx_valid), .rx_tagged(rx_tagged),
  .rx_other_prio(rx_other_prio), .queue_prio_valid_q(queue_prio_valid_q),
  .queue_prio_q(queue_prio_q));

// ### testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic [2:0] filter_drop_evt = 3'h0;
  logic [2:0] bcast_throttle_evt = 3'h0;
  logic [1:0] rx_valid = 2'h0;
  logic [1:0] rx_tagged = 2'h0;
  logic [2:0] rx_vlan_prio [2] = '{3'h0, 3'h0};
  logic [2:0] rx_other_prio [2] = '{3'h0, 3'h0};
  logic [1:0] queue_prio_valid_q;
  logic [2:0] queue_prio_q [2];
  logic [31:0] rd_val;
  logic [23:0] map;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  always #25 core_clk = ~core_clk;

  ircr_regs i_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .filter_drop_evt(filter_drop_evt),
    .bcast_throttle_evt(bcast_throttle_evt), .rx_valid(rx_valid), .rx_tagged(rx_tagged),
    .rx_vlan_prio(rx_vlan_prio), .rx_other_prio(rx_other_prio),
    .queue_prio_valid_q(queue_prio_valid_q), .queue_prio_q(queue_prio_q));

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A hung handshake must still reach the verdict.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task rd_raw(input logic [15:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk({31'h0, reg_rvalid_q}, 32'h1);
    rd_val = reg_rdata_q;
  endtask

  task rd(input logic [15:0] a, input logic [31:0] exp);
    rd_raw(a);
    chk(rd_val, exp);
  endtask

  // The status read is issued right behind the command so the pending window is seen.
  task rate_cmd(input logic rdc, input logic [4:0] idx);
    int i;
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ircr_pkg::ADDR_RATE_CMD;
    reg_wdata <= {1'b1, rdc, 25'h0, idx};
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= ircr_pkg::ADDR_RATE_CMD_STS;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk({31'h0, reg_rdata_q[0]}, 32'h1);
    for (i = 0; i < 8; i++) begin
      rd_raw(ircr_pkg::ADDR_RATE_CMD_STS);
      if (rd_val[0] === 1'b0) break;
    end
    chk({31'h0, rd_val[0]}, 32'h0);
  endtask

  task pulse(input logic [2:0] f, input logic [2:0] b, input int n);
    repeat (n) begin
      @(posedge core_clk);
      filter_drop_evt <= f;
      bcast_throttle_evt <= b;
      @(posedge core_clk);
      filter_drop_evt <= 3'h0;
      bcast_throttle_evt <= 3'h0;
    end
  endtask

  task rx(input int pt, input logic t, input logic [2:0] v, input logic [2:0] o,
          input logic [2:0] exp);
    @(posedge core_clk);
    rx_valid[pt] <= 1'b1;
    rx_tagged[pt] <= t;
    rx_vlan_prio[pt] <= v;
    rx_other_prio[pt] <= o;
    @(posedge core_clk);
    rx_valid[pt] <= 1'b0;
    @(negedge core_clk);
    chk({31'h0, queue_prio_valid_q[pt]}, 32'h1);
    chk({29'h0, queue_prio_q[pt]}, {29'h0, exp});
  endtask

  task t_reset_vals;
    int i;
    rd(ircr_pkg::ADDR_WR_STAGE, 32'h0);
    rd(ircr_pkg::ADDR_RD_STAGE, 32'h0);
    rd(ircr_pkg::ADDR_RATE_CMD_STS, 32'h0);
    rd(16'h1853, 32'h0);
    for (i = 0; i < 3; i++) rd(ircr_pkg::ADDR_FILT_CNT0 + 16'(i), 32'h0);
    for (i = 0; i < 8; i++) map[3*i +: 3] = 3'(i);
    rd(ircr_pkg::ADDR_REGEN_TBL0, {8'h00, map});
    rd(ircr_pkg::ADDR_REGEN_TBL1, {8'h00, map});
  endtask

  task t_staging;
    wr(ircr_pkg::ADDR_WR_STAGE, 32'hFFFF_FFFF);
    rd(ircr_pkg::ADDR_WR_STAGE, 32'h0000_FFFF);
    wr(ircr_pkg::ADDR_RD_STAGE, 32'h0000_FFFF);
    rd(ircr_pkg::ADDR_RD_STAGE, 32'h0);
  endtask

  task t_rate;
    rate_cmd(1'b1, 5'h17);
    rd(ircr_pkg::ADDR_RD_STAGE, 32'h0014);
    rate_cmd(1'b1, 5'h18);
    rd(ircr_pkg::ADDR_RD_STAGE, 32'h0600);
    rate_cmd(1'b1, 5'h19);
    rd(ircr_pkg::ADDR_RD_STAGE, 32'h0600);
    wr(ircr_pkg::ADDR_WR_STAGE, 32'h0000_A5C3);
    rate_cmd(1'b0, 5'h00);
    rd(ircr_pkg::ADDR_RD_STAGE, 32'h0600);
    rate_cmd(1'b1, 5'h00);
    rd(ircr_pkg::ADDR_RD_STAGE, 32'hA5C3);
    rate_cmd(1'b1, 5'h1A);
    rd(ircr_pkg::ADDR_RD_STAGE, 32'h0);
    rd(ircr_pkg::ADDR_RATE_CMD, 32'h4000_001A);
  endtask

  task t_counters;
    pulse(3'b001, 3'b000, 3);
    pulse(3'b000, 3'b010, 2);
    pulse(3'b100, 3'b100, 1);
    pulse(3'b100, 3'b000, 1);
    rd(ircr_pkg::ADDR_FILT_CNT0, 32'h3);
    rd(ircr_pkg::ADDR_FILT_CNT0, 32'h0);
    rd(ircr_pkg::ADDR_FILT_CNT1, 32'h2);
    rd(ircr_pkg::ADDR_FILT_CNT2, 32'h2);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= ircr_pkg::ADDR_FILT_CNT0;
    filter_drop_evt <= 3'b001;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    filter_drop_evt <= 3'b000;
    @(negedge core_clk);
    chk(reg_rdata_q, 32'h0);
    rd(ircr_pkg::ADDR_FILT_CNT0, 32'h1);
  endtask

  task t_regen;
    int p;
    for (p = 0; p < 8; p++) rx(1, 1'b1, 3'(p), ~3'(p), 3'(p));
    rx(1, 1'b0, 3'h5, 3'h2, 3'h2);
    for (p = 0; p < 8; p++) map[3*p +: 3] = 3'(7 - p);
    wr(ircr_pkg::ADDR_REGEN_TBL0, {8'hFF, map});
    rd(ircr_pkg::ADDR_REGEN_TBL0, {8'h00, map});
    for (p = 0; p < 8; p++) rx(0, 1'b1, 3'(p), 3'(p), 3'(7 - p));
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset_vals();
    t_staging();
    t_rate();
    t_counters();
    t_regen();
    tally_and_finish();
  end
endmodule
